// ===== logic/bfo_regs.sv
// Purpose: overhead register bank of the timing-line framer
// Assumes: processor strobes and line inputs synchronous to core_clk (200 MHz)
// Notes: capture registers update only in E1 mode; the received code register only in DS1 ESF
`timescale 1ns/10ps
module bfo_regs (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // mode
   input wire logic e1_mode,
   // processor port
   input wire bfo_pkg::bfo_proc_req_t proc_req,
   output logic [7:0] proc_rdata,
   // validated received code from the code filter
   input wire bfo_pkg::bfo_rx_code_t rx_code_in,
   // received E1 stream
   input wire bfo_pkg::bfo_e1_rx_t e1_rx,
   // transmit data link bit stream
   output logic tx_dl_valid,
   input wire logic tx_dl_ready,
   output logic tx_dl_bit,
   // interrupt
   output logic interrupt_request_pin
);
   // ************************************************************
   // processor decode
   // ************************************************************
   logic wr_en;
   logic rd_en;
   logic [7:0] wdata;
   logic [7:0] addr;

   // wr and rd are not expected together; each acts on its own
   assign wr_en = proc_req.cs && proc_req.wr;
   assign rd_en = proc_req.cs && proc_req.rd;
   assign wdata = proc_req.wdata;
   assign addr = proc_req.addr;

   // ************************************************************
   // transmit code control
   // ************************************************************
   logic send_code_enable_reg;
   logic [5:0] tx_code_field_reg;
   logic code_irq_en_reg;

   always_ff @(posedge core_clk) begin
      if (rst) begin
         send_code_enable_reg <= 1'b0;
      end else if (wr_en && addr == bfo_pkg::OFS_TX_CODE_CTRL) begin
         send_code_enable_reg <= wdata[bfo_pkg::SEND_CODE_BIT];
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         tx_code_field_reg <= '0;
      end else if (wr_en && addr == bfo_pkg::OFS_TX_CODE) begin
         tx_code_field_reg <= wdata[5:0];
      end
   end

   // the enable only masks the pin; the flag latches regardless
   always_ff @(posedge core_clk) begin
      if (rst) begin
         code_irq_en_reg <= 1'b0;
      end else if (wr_en && addr == bfo_pkg::OFS_RX_IRQ_EN4) begin
         code_irq_en_reg <= wdata[bfo_pkg::CODE_DET_BIT];
      end
   end

   // ************************************************************
   // transmit path: generator, FIFO, line
   // ************************************************************
   logic gen_valid;
   logic gen_ready;
   logic gen_bit;
   logic [0:0] fifo_out;

   // the generator never idles the line; back-pressure is its only pacing
   bfo_tx_gen u_tx_gen (
      .core_clk(core_clk),
      .rst(rst),
      .send_code_enable(send_code_enable_reg),
      .tx_code_field(tx_code_field_reg),
      .bit_valid(gen_valid),
      .bit_ready(gen_ready),
      .bit_data(gen_bit)
   );

   // the FIFO decouples message building from the line's bit timing
   bfo_fifo #(
      .WIDTH(1),
      .DEPTH(bfo_pkg::TX_FIFO_DEPTH)
   ) u_tx_fifo (
      .core_clk(core_clk),
      .rst(rst),
      .in_valid(gen_valid),
      .in_ready(gen_ready),
      .in_data(gen_bit),
      .out_valid(tx_dl_valid),
      .out_ready(tx_dl_ready),
      .out_data(fifo_out)
   );

   assign tx_dl_bit = fifo_out[0];

   // ************************************************************
   // received code and detected flag
   // ************************************************************
   logic [5:0] rx_code_field_reg;
   logic code_detected_flag_reg;
   logic code_store;

   assign code_store = rx_code_in.valid && !e1_mode;

   // upstream delivers the code with its earliest bit in bit 0
   always_ff @(posedge core_clk) begin
      if (rst) begin
         rx_code_field_reg <= '0;
      end else if (code_store) begin
         rx_code_field_reg <= rx_code_in.code;
      end
   end

   // a new detection in the clearing cycle keeps the flag set
   always_ff @(posedge core_clk) begin
      if (rst) begin
         code_detected_flag_reg <= 1'b0;
      end else if (code_store) begin
         code_detected_flag_reg <= 1'b1;
      end else if (wr_en && addr == bfo_pkg::OFS_RX_STATUS4
                   && wdata[bfo_pkg::CODE_DET_BIT]) begin
         code_detected_flag_reg <= 1'b0;
      end
   end

   assign interrupt_request_pin = code_detected_flag_reg && code_irq_en_reg;

   // ************************************************************
   // E1 frame header collection
   // ************************************************************
   logic [6:0] hdr_shift_reg;
   logic [3:0] hdr_cnt_reg;
   logic frame_align_reg;
   logic [2:0] frame_pair_reg;
   logic hdr_done;
   logic [7:0] hdr_byte;
   logic af_start;
   logic mf_start;

   assign af_start = e1_mode && e1_rx.bit_en && e1_rx.frame_start && e1_rx.is_align;
   assign mf_start = af_start && e1_rx.frame_num == 4'h0;
   assign hdr_byte = {hdr_shift_reg, e1_rx.data};
   assign hdr_done = e1_mode && e1_rx.bit_en && !e1_rx.frame_start
                     && hdr_cnt_reg == 4'(bfo_pkg::FRAME_HDR_BITS - 1);

   // first received bit ends up in bit 7
   // the count saturates at eight so later payload bits are ignored
   always_ff @(posedge core_clk) begin
      if (rst) begin
         hdr_shift_reg <= '0;
         hdr_cnt_reg <= 4'(bfo_pkg::FRAME_HDR_BITS);
         frame_align_reg <= 1'b0;
         frame_pair_reg <= '0;
      end else if (e1_mode && e1_rx.bit_en) begin
         hdr_shift_reg <= {hdr_shift_reg[5:0], e1_rx.data};
         if (e1_rx.frame_start) begin
            hdr_cnt_reg <= 4'h1;
            frame_align_reg <= e1_rx.is_align;
            frame_pair_reg <= e1_rx.frame_num[3:1];
         end else if (hdr_cnt_reg != 4'(bfo_pkg::FRAME_HDR_BITS)) begin
            hdr_cnt_reg <= hdr_cnt_reg + 1'b1;
         end
      end
   end

   // ************************************************************
   // per-frame holding and visible frame bytes
   // ************************************************************
   logic [7:0] align_hold_reg;
   logic [7:0] nonalign_hold_reg;
   logic [7:0] rx_align_byte_reg;
   logic [7:0] rx_nonalign_byte_reg;

   // a frame cut short before its eighth bit leaves the previous byte in place
   always_ff @(posedge core_clk) begin
      if (rst) begin
         align_hold_reg <= '0;
      end else if (hdr_done && frame_align_reg) begin
         align_hold_reg <= hdr_byte;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         nonalign_hold_reg <= '0;
      end else if (hdr_done && !frame_align_reg) begin
         nonalign_hold_reg <= hdr_byte;
      end
   end

   // bytes pass unaltered, so pattern, signal bit and alarm read as received
   always_ff @(posedge core_clk) begin
      if (rst) begin
         rx_align_byte_reg <= '0;
      end else if (af_start) begin
         rx_align_byte_reg <= align_hold_reg;
      end
   end

   // the non-align byte is refreshed at the align frame start, not its own
   always_ff @(posedge core_clk) begin
      if (rst) begin
         rx_nonalign_byte_reg <= '0;
      end else if (af_start) begin
         rx_nonalign_byte_reg <= nonalign_hold_reg;
      end
   end

   // ************************************************************
   // per-multiframe accumulators and visible copies
   // ************************************************************
   logic [7:0] acc_si_af_reg;
   logic [7:0] acc_si_naf_reg;
   logic [7:0] acc_rai_reg;
   logic [7:0] acc_sa4_reg;
   logic [7:0] acc_sa5_reg;
   logic [7:0] rx_si_af_reg;
   logic [7:0] rx_si_naf_reg;
   logic [7:0] rx_rai_reg;
   logic [7:0] rx_sa4_reg;
   logic [7:0] rx_sa5_reg;

   // frame n of a pair lands in bit n/2, so frame 0/1 in bit 0, 14/15 in bit 7
   genvar gi;
   generate
      for (gi = 0; gi < 8; gi++) begin : g_acc
         always_ff @(posedge core_clk) begin
            if (rst) begin
               acc_si_af_reg[gi] <= 1'b0;
               acc_si_naf_reg[gi] <= 1'b0;
               acc_rai_reg[gi] <= 1'b0;
               acc_sa4_reg[gi] <= 1'b0;
               acc_sa5_reg[gi] <= 1'b0;
            end else if (hdr_done && frame_pair_reg == 3'(gi)) begin
               if (frame_align_reg) begin
                  acc_si_af_reg[gi] <= hdr_byte[bfo_pkg::SI_BIT];
               end else begin
                  acc_si_naf_reg[gi] <= hdr_byte[bfo_pkg::SI_BIT];
                  acc_rai_reg[gi] <= hdr_byte[bfo_pkg::RAI_BIT];
                  acc_sa4_reg[gi] <= hdr_byte[bfo_pkg::SA4_BIT];
                  acc_sa5_reg[gi] <= hdr_byte[bfo_pkg::SA5_BIT];
               end
            end
         end
      end
   endgenerate

   // accumulators are never cleared, so a missing frame repeats its last bit
   always_ff @(posedge core_clk) begin
      if (rst) begin
         rx_si_af_reg <= '0;
         rx_si_naf_reg <= '0;
         rx_rai_reg <= '0;
         rx_sa4_reg <= '0;
         rx_sa5_reg <= '0;
      end else if (mf_start) begin
         rx_si_af_reg <= acc_si_af_reg;
         rx_si_naf_reg <= acc_si_naf_reg;
         rx_rai_reg <= acc_rai_reg;
         rx_sa4_reg <= acc_sa4_reg;
         rx_sa5_reg <= acc_sa5_reg;
      end
   end

   // ************************************************************
   // frame event flags
   // ************************************************************
   logic mf_flag_reg;
   logic af_flag_reg;
   logic st3_clr_mf;
   logic st3_clr_af;

   assign st3_clr_mf = wr_en && addr == bfo_pkg::OFS_RX_STATUS3 && wdata[bfo_pkg::MF_FLAG_BIT];
   assign st3_clr_af = wr_en && addr == bfo_pkg::OFS_RX_STATUS3 && wdata[bfo_pkg::AF_FLAG_BIT];

   // set beats clear so no boundary is missed
   always_ff @(posedge core_clk) begin
      if (rst) begin
         mf_flag_reg <= 1'b0;
      end else if (mf_start) begin
         mf_flag_reg <= 1'b1;
      end else if (st3_clr_mf) begin
         mf_flag_reg <= 1'b0;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         af_flag_reg <= 1'b0;
      end else if (af_start) begin
         af_flag_reg <= 1'b1;
      end else if (st3_clr_af) begin
         af_flag_reg <= 1'b0;
      end
   end

   // ************************************************************
   // read back
   // ************************************************************
   logic [7:0] rd_mux;

   // capture registers have no write decode at all
   // reads have no side effects, so polling a flag never clears it
   always_comb begin
      rd_mux = bfo_pkg::REG_RESET;
      unique case (addr)
         bfo_pkg::OFS_RX_STATUS3: begin
            rd_mux[bfo_pkg::MF_FLAG_BIT] = mf_flag_reg;
            rd_mux[bfo_pkg::AF_FLAG_BIT] = af_flag_reg;
         end
         bfo_pkg::OFS_RX_STATUS4: rd_mux[bfo_pkg::CODE_DET_BIT] = code_detected_flag_reg;
         bfo_pkg::OFS_RX_IRQ_EN4: rd_mux[bfo_pkg::CODE_DET_BIT] = code_irq_en_reg;
         bfo_pkg::OFS_TX_CODE_CTRL: rd_mux[bfo_pkg::SEND_CODE_BIT] = send_code_enable_reg;
         bfo_pkg::OFS_RX_CODE: rd_mux = {2'b00, rx_code_field_reg};
         bfo_pkg::OFS_TX_CODE: rd_mux = {2'b00, tx_code_field_reg};
         bfo_pkg::OFS_RX_ALIGN: rd_mux = rx_align_byte_reg;
         bfo_pkg::OFS_RX_NONALIGN: rd_mux = rx_nonalign_byte_reg;
         bfo_pkg::OFS_RX_SI_ALIGN: rd_mux = rx_si_af_reg;
         bfo_pkg::OFS_RX_SI_NONALIGN: rd_mux = rx_si_naf_reg;
         bfo_pkg::OFS_RX_RAI: rd_mux = rx_rai_reg;
         bfo_pkg::OFS_RX_SA4: rd_mux = rx_sa4_reg;
         bfo_pkg::OFS_RX_SA5: rd_mux = rx_sa5_reg;
         default: rd_mux = bfo_pkg::REG_RESET;
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         proc_rdata <= '0;
      end else if (rd_en) begin
         proc_rdata <= rd_mux;
      end
   end
endmodule

// ===== logic/bfo_pkg.sv
// Purpose: constants and carrier types for the framer overhead register bank
// Assumes: 8-bit processor port, one clock (core_clk), synchronous active-high reset
package bfo_pkg;
   // ************************************************************
   // register offsets
   // ************************************************************
   localparam logic [7:0] OFS_RX_STATUS3 = 8'h36;
   localparam logic [7:0] OFS_RX_STATUS4 = 8'h38;
   localparam logic [7:0] OFS_RX_IRQ_EN4 = 8'h39;
   localparam logic [7:0] OFS_TX_CODE_CTRL = 8'h41;
   localparam logic [7:0] OFS_RX_CODE = 8'h42;
   localparam logic [7:0] OFS_TX_CODE = 8'h43;
   localparam logic [7:0] OFS_RX_ALIGN = 8'h50;
   localparam logic [7:0] OFS_RX_NONALIGN = 8'h51;
   localparam logic [7:0] OFS_RX_SI_ALIGN = 8'h52;
   localparam logic [7:0] OFS_RX_SI_NONALIGN = 8'h53;
   localparam logic [7:0] OFS_RX_RAI = 8'h54;
   localparam logic [7:0] OFS_RX_SA4 = 8'h55;
   localparam logic [7:0] OFS_RX_SA5 = 8'h56;
   // ************************************************************
   // field positions and reset values
   // ************************************************************
   localparam int SEND_CODE_BIT = 6;
   localparam int CODE_DET_BIT = 0;
   localparam int MF_FLAG_BIT = 0;
   localparam int AF_FLAG_BIT = 1;
   localparam int SI_BIT = 7;
   localparam int RAI_BIT = 5;
   localparam int SA4_BIT = 4;
   localparam int SA5_BIT = 3;
   localparam logic [7:0] REG_RESET = 8'h00;
   // ************************************************************
   // data link message
   // ************************************************************
   localparam int MSG_BITS = 16;
   localparam logic [15:0] IDLE_MSG = 16'h7e7e;
   localparam logic [7:0] CODE_PREAMBLE = 8'hff;
   localparam int TX_FIFO_DEPTH = 8;
   localparam int FRAME_HDR_BITS = 8;
   // ************************************************************
   // carriers
   // ************************************************************
   typedef struct packed {
      logic cs;
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } bfo_proc_req_t;
   typedef struct packed {
      logic valid;
      logic [5:0] code;
   } bfo_rx_code_t;
   typedef struct packed {
      logic bit_en;
      logic data;
      logic frame_start;
      logic is_align;
      logic [3:0] frame_num;
   } bfo_e1_rx_t;
endpackage

// ===== logic/bfo_fifo.sv
// Purpose: small synchronous FIFO with valid/ready on both sides
// Assumes: one clock, synchronous active-high reset
// Notes: depth must be a power of two
`timescale 1ns/10ps
module bfo_fifo #(
   parameter int WIDTH = 1,
   parameter int DEPTH = 8
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0] wr_ptr_reg;
   logic [AW:0] rd_ptr_reg;
   logic push;
   logic pop;

   assign in_ready = (wr_ptr_reg - rd_ptr_reg) != (AW+1)'(DEPTH);
   assign out_valid = wr_ptr_reg != rd_ptr_reg;
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;
   assign out_data = mem[rd_ptr_reg[AW-1:0]];

   always_ff @(posedge core_clk) begin
      if (push) begin
         mem[wr_ptr_reg[AW-1:0]] <= in_data;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
      end else begin
         if (push) begin
            wr_ptr_reg <= wr_ptr_reg + 1'b1;
         end
         if (pop) begin
            rd_ptr_reg <= rd_ptr_reg + 1'b1;
         end
      end
   end
endmodule

// ===== logic/bfo_tx_gen.sv
// Purpose: builds the 16-bit data link messages, code or idle flags, bit by bit
// Assumes: one clock, synchronous active-high reset
// Notes: stalls while the downstream FIFO is full
`timescale 1ns/10ps
module bfo_tx_gen (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // settings from software
   input wire logic send_code_enable,
   input wire logic [5:0] tx_code_field,
   // bit stream out
   output logic bit_valid,
   input wire logic bit_ready,
   output logic bit_data
);
   logic [15:0] msg_reg;
   logic [3:0] idx_reg;
   logic [15:0] msg_next;

   // code message: 8 ones, a zero, six code bits, a zero, sent lsb first
   always_comb begin
      if (send_code_enable) begin
         msg_next = {1'b0, tx_code_field, 1'b0, bfo_pkg::CODE_PREAMBLE};
      end else begin
         msg_next = bfo_pkg::IDLE_MSG;
      end
   end

   assign bit_valid = 1'b1;
   assign bit_data = msg_reg[idx_reg];

   // the settings are sampled only when a message is finished, never mid-message
   always_ff @(posedge core_clk) begin
      if (rst) begin
         msg_reg <= bfo_pkg::IDLE_MSG;
         idx_reg <= '0;
      end else if (bit_ready) begin
         idx_reg <= idx_reg + 1'b1;
         if (idx_reg == 4'(bfo_pkg::MSG_BITS - 1)) begin
            msg_reg <= msg_next;
         end
      end
   end
endmodule

// ===== test/bfo_regs_checker.sv
// Purpose: port assertions for the overhead register bank
// Assumes: synchronous active-high reset, one clock
// Notes: flags are mirrored from port traffic alone
`timescale 1ns/10ps
module bfo_regs_checker (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // block inputs
   input wire logic e1_mode,
   input wire bfo_pkg::bfo_proc_req_t proc_req,
   input wire bfo_pkg::bfo_rx_code_t rx_code_in,
   input wire bfo_pkg::bfo_e1_rx_t e1_rx,
   input wire logic tx_dl_ready,
   // block outputs
   input wire logic [7:0] proc_rdata,
   input wire logic tx_dl_valid,
   input wire logic tx_dl_bit,
   input wire logic interrupt_request_pin
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);
   logic rd, wr, code_ev, af_ev, pop, idle, r50, w50, cd_reg, en_reg, done_reg;
   logic [7:0] a, wd;
   logic [1:0] fl_reg;
   logic [5:0] code_reg;
   logic [3:0] cnt_reg;
   logic [15:0] msg_reg;
   assign a = proc_req.addr;
   assign rd = proc_req.cs && proc_req.rd;
   assign wr = proc_req.cs && proc_req.wr;
   assign wd = wr ? proc_req.wdata : 8'h00;
   assign code_ev = rx_code_in.valid && !e1_mode;
   assign af_ev = e1_mode && e1_rx.bit_en && e1_rx.frame_start && e1_rx.is_align;
   assign pop = tx_dl_valid && tx_dl_ready;
   assign idle = !proc_req.cs && !e1_rx.bit_en;
   assign r50 = rd && a == 8'h50 && !e1_rx.bit_en;
   assign w50 = wr && a == 8'h50 && !e1_rx.bit_en;
   // ****
   // flag mirrors; a set in the clearing cycle wins
   // ****
   always_ff @(posedge core_clk) begin
      if (rst) begin
         cd_reg <= 1'b0;
         en_reg <= 1'b0;
         fl_reg <= 2'b00;
         code_reg <= 6'h00;
      end else begin
         cd_reg <= code_ev || (cd_reg && !(a == 8'h38 && wd[0]));
         fl_reg <= (fl_reg & ~(a == 8'h36 ? wd[1:0] : 2'b00))
            | {af_ev, af_ev && e1_rx.frame_num == 4'h0};
         if (wr && a == 8'h39) en_reg <= wd[0];
         if (code_ev) code_reg <= rx_code_in.code;
      end
   end
   // message assembler, aligned to the first bit after reset
   always_ff @(posedge core_clk) begin
      if (rst) begin
         cnt_reg <= 4'h0;
         msg_reg <= 16'h0000;
      end else if (pop) begin
         cnt_reg <= cnt_reg + 4'h1;
         msg_reg <= {tx_dl_bit, msg_reg[15:1]};
      end
      done_reg <= !rst && pop && cnt_reg == 4'hf;
   end
   property p_code_rd; rd && a == 8'h42 |=> proc_rdata == {2'b00, $past(code_reg)}; endproperty
   a_code_rd: assert property (p_code_rd) else $error("rx code readback wrong");
   property p_sr4; rd && a == 8'h38 |=> proc_rdata == {7'h00, $past(cd_reg)}; endproperty
   a_sr4: assert property (p_sr4) else $error("code flag readback wrong");
   property p_sr3; rd && a == 8'h36 |=> proc_rdata == {6'h00, $past(fl_reg)}; endproperty
   a_sr3: assert property (p_sr3) else $error("frame flags wrong");
   property p_irq; interrupt_request_pin == (cd_reg && en_reg); endproperty
   a_irq: assert property (p_irq) else $error("interrupt level wrong");
   property p_msg; done_reg |-> msg_reg == 16'h7e7e || (msg_reg[8:0] == 9'h0ff && !msg_reg[15]);
   endproperty
   a_msg: assert property (p_msg) else $error("partial message sent");
   property p_hold; tx_dl_valid && !tx_dl_ready |=> tx_dl_valid && $stable(tx_dl_bit); endproperty
   a_hold: assert property (p_hold) else $error("link bit lost");
   property p_ro; r50 ##1 idle ##1 w50 ##1 idle ##1 r50 |=> $stable(proc_rdata); endproperty
   a_ro: assert property (p_ro) else $error("capture register written");
   property p_rst; $fell(rst) |-> proc_rdata == 8'h00 && !tx_dl_valid && !interrupt_request_pin;
   endproperty
   a_rst: assert property (p_rst) else $error("reset state wrong");
endmodule

bind bfo_regs bfo_regs_checker u_chk (
   .core_clk(core_clk), .rst(rst), .e1_mode(e1_mode), .proc_req(proc_req),
   .rx_code_in(rx_code_in), .e1_rx(e1_rx), .tx_dl_ready(tx_dl_ready),
   .proc_rdata(proc_rdata), .tx_dl_valid(tx_dl_valid), .tx_dl_bit(tx_dl_bit),
   .interrupt_request_pin(interrupt_request_pin)
);

// ===== test/bfo_line_model.sv
// Purpose: remote line equipment facing the register bank
// Assumes: one line bit per core_clk in each direction
// Notes: ready drops while stall is high to back up the FIFO
`timescale 1ns/10ps
module bfo_line_model (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // back-pressure request
   input wire logic stall,
   // receive line into the block
   output bfo_pkg::bfo_e1_rx_t e1_rx,
   // transmit data link out of the block
   input wire logic tx_dl_valid,
   output logic tx_dl_ready,
   input wire logic tx_dl_bit
);
   logic q[$];
   initial begin
      e1_rx = '0;
      tx_dl_ready = 1'b0;
   end
   always @(posedge core_clk) begin
      if (rst) q.delete();
      else if (tx_dl_valid && tx_dl_ready) q.push_back(tx_dl_bit);
      tx_dl_ready <= !stall && !rst;
   end
   // header goes out bit 7 first; data inverts when idle so no stale bit lingers
   task automatic send_frame(input logic [3:0] num, input logic align, input logic [7:0] hdr);
      for (int i = 0; i < 8; i++) begin
         @(posedge core_clk);
         e1_rx <= {1'b1, hdr[7 - i], i == 0, align, num};
      end
      @(posedge core_clk);
      e1_rx <= {1'b0, !hdr[0], 1'b0, 1'b0, 4'h0};
   endtask
endmodule

// ===== test/bfo_regs_tb.sv
// Purpose: self-checking bench for the overhead register bank
// Assumes: 200 MHz core_clk, line model on the far side
// Notes: scenario tasks drive and judge in turn; t_e1 expects the rx code left by t_rxcode
`timescale 1ns/10ps
module bfo_regs_tb;
   logic core_clk, rst, e1_mode, stall, tx_dl_valid, tx_dl_ready, tx_dl_bit, irq;
   bfo_pkg::bfo_proc_req_t proc_req;
   bfo_pkg::bfo_rx_code_t rx_code_in;
   bfo_pkg::bfo_e1_rx_t e1_rx;
   logic [7:0] proc_rdata;
   int failures, checks, cyc;
   bfo_regs u_dut (
      .core_clk(core_clk), .rst(rst), .e1_mode(e1_mode), .proc_req(proc_req),
      .proc_rdata(proc_rdata), .rx_code_in(rx_code_in), .e1_rx(e1_rx),
      .tx_dl_valid(tx_dl_valid), .tx_dl_ready(tx_dl_ready), .tx_dl_bit(tx_dl_bit),
      .interrupt_request_pin(irq)
   );
   bfo_line_model u_line (
      .core_clk(core_clk), .rst(rst), .stall(stall), .e1_rx(e1_rx),
      .tx_dl_valid(tx_dl_valid), .tx_dl_ready(tx_dl_ready), .tx_dl_bit(tx_dl_bit)
   );
   initial begin
      core_clk = 1'b0;
      forever #2.5 core_clk = ~core_clk;
   end
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 5000) begin
         failures++;
         end_sim();
      end
   end
   task automatic end_sim;
      if (failures == 0 && checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp) begin
         failures++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // one access, then an idle cycle; data is read once the edge has landed
   task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk);
      proc_req <= '{1'b1, w, !w, a, d};
      @(posedge core_clk);
      proc_req <= '0;
      @(negedge core_clk);
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
      acc(1'b0, a, 8'h00);
      chk({8'h00, proc_rdata}, {8'h00, exp});
   endtask
   task automatic pulse(input logic [5:0] c);
      @(posedge core_clk);
      rx_code_in <= '{1'b1, c};
      @(posedge core_clk);
      rx_code_in <= '{1'b0, ~c};
   endtask
   function automatic logic [15:0] msg(input int k);
      for (int i = 0; i < 16; i++) msg[i] = u_line.q[16 * k + i];
   endfunction
   // stalls the line meanwhile; a switch shows two messages later at the latest
   task automatic tx_expect(input logic [15:0] exp);
      int m;
      m = u_line.q.size() / 16 + 1;
      @(posedge core_clk);
      stall <= 1'b1;
      repeat (20) @(posedge core_clk);
      stall <= 1'b0;
      for (int i = 0; i < 500 && u_line.q.size() < 16 * m + 48; i++) @(posedge core_clk);
      chk(msg(m + 2), exp);
   endtask
   task automatic t_reset;
      logic [7:0] ofs [7] = '{8'h36, 8'h38, 8'h39, 8'h41, 8'h42, 8'h43, 8'h7f};
      foreach (ofs[i]) rdchk(ofs[i], 8'h00);
      for (int a = 8'h50; a <= 8'h56; a++) rdchk(8'(a), 8'h00);
   endtask
   task automatic t_tx;
      logic [5:0] codes [2] = '{6'h2d, 6'h3f};
      tx_expect(16'h7e7e);
      foreach (codes[i]) begin
         acc(1'b1, 8'h43, {2'b00, codes[i]});
         acc(1'b1, 8'h41, 8'h40);
         tx_expect({1'b0, codes[i], 1'b0, 8'hff});
      end
      rdchk(8'h43, 8'h3f);
      rdchk(8'h41, 8'h40);
      acc(1'b1, 8'h41, 8'h00);
      tx_expect(16'h7e7e);
   endtask
   task automatic t_rxcode;
      pulse(6'h2a);
      rdchk(8'h42, 8'h2a);
      rdchk(8'h38, 8'h01);
      chk({15'h0000, irq}, 16'h0000);
      acc(1'b1, 8'h39, 8'h01);
      chk({15'h0000, irq}, 16'h0001);
      acc(1'b1, 8'h38, 8'h01);
      rdchk(8'h38, 8'h00);
      chk({15'h0000, irq}, 16'h0000);
      acc(1'b1, 8'h42, 8'h15);
      rdchk(8'h42, 8'h2a);
   endtask
   task automatic t_e1;
      logic [15:0] si = 16'h5ac3;
      logic [7:0] ra = 8'hb4, s4 = 8'h69, s5 = 8'h1e, ev, od, b;
      @(posedge core_clk);
      e1_mode <= 1'b1;
      pulse(6'h11);
      for (int n = 0; n < 17; n++) begin
         b = n[0] ? {si[n % 16], 1'b1, ra[n / 2], s4[n / 2], s5[n / 2], 3'b101}
            : {si[n % 16], 7'b0011011};
         u_line.send_frame(4'(n % 16), !n[0], b);
      end
      for (int k = 0; k < 8; k++) begin
         ev[k] = si[2 * k];
         od[k] = si[2 * k + 1];
      end
      rdchk(8'h42, 8'h2a);
      rdchk(8'h51, {si[15], 1'b1, ra[7], s4[7], s5[7], 3'b101});
      rdchk(8'h50, {si[14], 7'b0011011});
      acc(1'b1, 8'h50, 8'hff);
      rdchk(8'h50, {si[14], 7'b0011011});
      rdchk(8'h52, ev);
      rdchk(8'h53, od);
      rdchk(8'h54, ra);
      rdchk(8'h55, s4);
      rdchk(8'h56, s5);
      rdchk(8'h36, 8'h03);
      acc(1'b1, 8'h36, 8'h02);
      rdchk(8'h36, 8'h01);
   endtask
   initial begin
      rst = 1'b1;
      e1_mode = 1'b0;
      stall = 1'b0;
      proc_req = '0;
      rx_code_in = '0;
      failures = 0;
      checks = 0;
      cyc = 0;
      repeat (12) @(posedge core_clk);
      rst <= 1'b0;
      t_reset();
      t_tx();
      t_rxcode();
      t_e1();
      end_sim();
   end
endmodule
